// ===== rtl/fsy_consts.vh
`ifndef FSY_CONSTS_VH
`define FSY_CONSTS_VH
// ----------------------------------------
// widths
// ----------------------------------------
`define FSY_TW 16
`define FSY_NUM_EVT 30
`define FSY_WDOG_W 24
`define FSY_GPS_W 32
// ----------------------------------------
// timing counts
// ----------------------------------------
`define FSY_FRAME_TC 16'h95ff
`define FSY_TICK_DIV 5'h19
`define FSY_FCLK_HIGH 16'h0780
`define FSY_ZERO_T 16'h0000
`define FSY_ONE_T 16'h0001
`define FSY_TICK_ONE 5'h01
`define FSY_WDOG_ONE 24'h000001
`define FSY_GPS_ONE 32'h00000001
// ----------------------------------------
// timer index and source select codes
// ----------------------------------------
`define FSY_T_ANT 0
`define FSY_T_SYS 1
`define FSY_SRC_ALT 1'b0
`define FSY_SRC_TICK 1'b1
`endif

// ===== rtl/fsy_event_gen.v
`timescale 1ns/1ps
`include "fsy_consts.vh"
// ----------------------------------------
// one timed event: period and offset against the chosen timer
// ----------------------------------------
module fsy_event_gen (
   input wire sys_clk,
   input wire arst_n,
   input wire enable,
   input wire timer_sel,
   input wire [`FSY_TW-1:0] period,
   input wire [`FSY_TW-1:0] offset,
   input wire tick_ant,
   input wire tick_sys,
   input wire frame_ant,
   input wire frame_sys,
   output wire strobe
);
   reg [`FSY_TW-1:0] phase_reg;
   reg [`FSY_TW-1:0] phase_next;
   reg strobe_reg;
   reg strobe_next;
   wire tick;
   wire frame;

   assign tick = timer_sel ? tick_sys : tick_ant;
   assign frame = timer_sel ? frame_sys : frame_ant;

   always @* begin
      phase_next = phase_reg;
      strobe_next = 1'b0;
      if (frame) begin
         phase_next = `FSY_ZERO_T;
         strobe_next = enable & (offset == `FSY_ZERO_T);
      end else if (tick) begin
         if (phase_reg >= period) begin
            phase_next = `FSY_ZERO_T;
         end else begin
            phase_next = phase_reg + `FSY_ONE_T;
         end
         strobe_next = enable & (phase_next == offset);
      end
   end

   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         phase_reg <= `FSY_ZERO_T;
         strobe_reg <= 1'b0;
      end else begin
         phase_reg <= phase_next;
         strobe_reg <= strobe_next;
      end
   end

   assign strobe = strobe_reg;
endmodule // fsy_event_gen

// ===== rtl/fsy_frame_timing.v
// Overview of operation
// - three sync pairs, align to any one
// - burst plus its clock form sync interface
// - alt_frame_sync high sample marks frame start
// - alt pair aligns antenna timer without RP1
// - system_tick_sync high sample marks system boundary
// - tick pair aligns system timer, any rate
// - frame alignment exported on frame_clock_out
// - watchdog flags missing RP1 sync update
// - antenna_frame_timer tracks frame time for events
// - gps_time_counter holds time of day
// - system timer follows burst in RP1 mode
// - timers separate, each event picks one
// - thirty programmable timed events
// - periodic strobes with period and offset
// - events broadcast to cores, DMA, timers
// - dedicated error and alarm event lines
// - timing via events and readable timer values
// - after reset non-RP1 mode, bit 0
// - count after sync and arm, halt stops
// - outputs low during reset
`timescale 1ns/1ps
`include "fsy_consts.vh"
module fsy_frame_timing (
   input wire sys_clk,
   input wire arst_n,
   input wire rp1_sync_burst,
   input wire rp1_sync_clock,
   input wire alt_frame_sync,
   input wire alt_frame_clock,
   input wire system_tick_sync,
   input wire system_tick_clock,
   input wire sync_mode,
   input wire sys_src_sel,
   input wire [1:0] timer_arm,
   input wire [1:0] timer_halt,
   input wire [`FSY_WDOG_W-1:0] wdog_limit,
   input wire [`FSY_GPS_W-1:0] gps_time_init,
   input wire [`FSY_NUM_EVT-1:0] evt_enable,
   input wire [`FSY_NUM_EVT-1:0] evt_timer_sel,
   input wire [`FSY_NUM_EVT*`FSY_TW-1:0] evt_period,
   input wire [`FSY_NUM_EVT*`FSY_TW-1:0] evt_offset,
   output wire [`FSY_NUM_EVT-1:0] system_event,
   output wire frame_clock_out,
   output wire error_event,
   output wire alarm_event,
   output wire [`FSY_TW-1:0] antenna_frame_timer,
   output wire [`FSY_TW-1:0] system_timer,
   output wire [`FSY_GPS_W-1:0] gps_time_counter,
   output wire wdog_expired,
   output wire [1:0] timer_running
);
   // ----------------------------------------
   // timer state codes
   // ----------------------------------------
   localparam ST_IDLE = 4'h1;
   localparam ST_WAIT = 4'h2;
   localparam ST_RUN = 4'h4;
   localparam ST_HALT = 4'h8;

   // ----------------------------------------
   // sync pair capture
   // ----------------------------------------
   wire bnd_rp1;
   wire bnd_alt;
   wire bnd_tick;

   // burst decoding is not done here: a high burst bit sampled on the
   // sync clock is taken as the frame mark
   fsy_sync_capture u_cap_rp1 (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .sync_pin(rp1_sync_burst),
      .clock_pin(rp1_sync_clock),
      .boundary(bnd_rp1)
   );

   fsy_sync_capture u_cap_alt (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .sync_pin(alt_frame_sync),
      .clock_pin(alt_frame_clock),
      .boundary(bnd_alt)
   );

   fsy_sync_capture u_cap_tick (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .sync_pin(system_tick_sync),
      .clock_pin(system_tick_clock),
      .boundary(bnd_tick)
   );

   // ----------------------------------------
   // mode and source selection
   // ----------------------------------------
   reg mode_reg;
   wire [1:0] bnd_sel;

   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         mode_reg <= 1'b0;
      end else begin
         mode_reg <= sync_mode;
      end
   end

   assign bnd_sel[`FSY_T_ANT] = mode_reg ? bnd_rp1 : bnd_alt;
   // in burst mode both timers follow the burst frame mark
   assign bnd_sel[`FSY_T_SYS] = mode_reg ? bnd_rp1 :
      ((sys_src_sel == `FSY_SRC_TICK) ? bnd_tick : bnd_alt);

   // ----------------------------------------
   // chip tick divider
   // ----------------------------------------
   reg [4:0] div_reg;
   reg tick_reg;

   // the chip rate is no integer fraction of sys_clk; the divider
   // gives a nearby rate and the frame marks keep the timers aligned
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         div_reg <= 5'h00;
         tick_reg <= 1'b0;
      end else begin
         if (div_reg == `FSY_TICK_DIV) begin
            div_reg <= 5'h00;
            tick_reg <= 1'b1;
         end else begin
            div_reg <= div_reg + `FSY_TICK_ONE;
            tick_reg <= 1'b0;
         end
      end
   end

   // ----------------------------------------
   // antenna frame timer and system timer
   // ----------------------------------------
   wire [2*`FSY_TW-1:0] tmr_all;
   wire [1:0] frame_all;
   wire [1:0] tick_all;
   wire [1:0] run_all;
   wire [1:0] start_all;
   wire [1:0] misalign_all;

   genvar k;
   generate
      for (k = 0; k < 2; k = k + 1) begin : g_tmr
         reg [3:0] st_reg;
         reg [`FSY_TW-1:0] cnt_reg;
         reg frame_reg;
         reg tickq_reg;
         reg start_reg;
         reg misalign_reg;
         wire at_tc;

         assign at_tc = (cnt_reg == `FSY_FRAME_TC);

         always @(posedge sys_clk or negedge arst_n) begin
            if (!arst_n) begin
               st_reg <= ST_IDLE;
               cnt_reg <= `FSY_ZERO_T;
               frame_reg <= 1'b0;
               tickq_reg <= 1'b0;
               start_reg <= 1'b0;
               misalign_reg <= 1'b0;
            end else begin
               frame_reg <= 1'b0;
               tickq_reg <= 1'b0;
               start_reg <= 1'b0;
               misalign_reg <= 1'b0;
               case (st_reg)
                  ST_IDLE: begin
                     if (timer_arm[k]) begin
                        st_reg <= ST_WAIT;
                     end
                  end
                  ST_WAIT: begin
                     if (!timer_arm[k]) begin
                        st_reg <= ST_IDLE;
                     end else if (bnd_sel[k]) begin
                        st_reg <= ST_RUN;
                        cnt_reg <= `FSY_ZERO_T;
                        frame_reg <= 1'b1;
                        start_reg <= 1'b1;
                     end
                  end
                  ST_RUN: begin
                     if (!timer_arm[k]) begin
                        st_reg <= ST_IDLE;
                     end else if (timer_halt[k]) begin
                        st_reg <= ST_HALT;
                     end else if (bnd_sel[k]) begin
                        // realign; a mark away from the frame edge is an alarm
                        cnt_reg <= `FSY_ZERO_T;
                        frame_reg <= 1'b1;
                        misalign_reg <= ~at_tc & (cnt_reg != `FSY_ZERO_T);
                     end else if (tick_reg) begin
                        tickq_reg <= 1'b1;
                        if (at_tc) begin
                           cnt_reg <= `FSY_ZERO_T;
                           frame_reg <= 1'b1;
                        end else begin
                           cnt_reg <= cnt_reg + `FSY_ONE_T;
                        end
                     end
                  end
                  ST_HALT: begin
                     if (!timer_arm[k]) begin
                        st_reg <= ST_IDLE;
                     end else if (!timer_halt[k]) begin
                        st_reg <= ST_RUN;
                     end
                  end
                  default: begin
                     st_reg <= ST_IDLE;
                  end
               endcase
            end
         end

         assign tmr_all[k*`FSY_TW +: `FSY_TW] = cnt_reg;
         assign frame_all[k] = frame_reg;
         assign tick_all[k] = tickq_reg;
         assign run_all[k] = (st_reg == ST_RUN);
         assign start_all[k] = start_reg;
         assign misalign_all[k] = misalign_reg;
      end
   endgenerate

   // ----------------------------------------
   // time of day
   // ----------------------------------------
   reg [`FSY_GPS_W-1:0] gps_reg;

   // counts antenna frames from the value loaded at the first frame mark
   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         gps_reg <= {`FSY_GPS_W{1'b0}};
      end else if (start_all[`FSY_T_ANT]) begin
         gps_reg <= gps_time_init;
      end else if (frame_all[`FSY_T_ANT]) begin
         gps_reg <= gps_reg + `FSY_GPS_ONE;
      end
   end

   // ----------------------------------------
   // watchdog on burst updates
   // ----------------------------------------
   reg [`FSY_WDOG_W-1:0] wd_cnt_reg;
   reg wd_exp_reg;
   reg err_reg;
   wire wd_hit;

   // only watched while in burst mode with the antenna timer armed
   assign wd_hit = mode_reg & timer_arm[`FSY_T_ANT] & ~bnd_rp1 & (wd_cnt_reg == wdog_limit);

   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         wd_cnt_reg <= {`FSY_WDOG_W{1'b0}};
         wd_exp_reg <= 1'b0;
         err_reg <= 1'b0;
      end else begin
         err_reg <= wd_hit;
         if (!mode_reg || !timer_arm[`FSY_T_ANT]) begin
            wd_cnt_reg <= {`FSY_WDOG_W{1'b0}};
            wd_exp_reg <= 1'b0;
         end else if (bnd_rp1 || wd_hit) begin
            wd_cnt_reg <= {`FSY_WDOG_W{1'b0}};
            // a clearing mark wins over expiry in the same cycle
            wd_exp_reg <= wd_hit | (wd_exp_reg & ~bnd_rp1);
         end else begin
            wd_cnt_reg <= wd_cnt_reg + `FSY_WDOG_ONE;
         end
      end
   end

   // ----------------------------------------
   // alarm and exported frame clock
   // ----------------------------------------
   reg alarm_reg;
   reg fclk_reg;
   reg [1:0] run_reg;

   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         alarm_reg <= 1'b0;
         fclk_reg <= 1'b0;
         run_reg <= 2'h0;
      end else begin
         alarm_reg <= |misalign_all;
         fclk_reg <= run_all[`FSY_T_ANT] & (tmr_all[`FSY_TW-1:0] < `FSY_FCLK_HIGH);
         run_reg <= run_all;
      end
   end

   // ----------------------------------------
   // event generators
   // ----------------------------------------
   genvar e;
   generate
      for (e = 0; e < `FSY_NUM_EVT; e = e + 1) begin : g_evt
         fsy_event_gen u_evt (
            .sys_clk(sys_clk),
            .arst_n(arst_n),
            .enable(evt_enable[e]),
            .timer_sel(evt_timer_sel[e]),
            .period(evt_period[e*`FSY_TW +: `FSY_TW]),
            .offset(evt_offset[e*`FSY_TW +: `FSY_TW]),
            .tick_ant(tick_all[`FSY_T_ANT]),
            .tick_sys(tick_all[`FSY_T_SYS]),
            .frame_ant(frame_all[`FSY_T_ANT]),
            .frame_sys(frame_all[`FSY_T_SYS]),
            .strobe(system_event[e])
         );
      end
   endgenerate

   // ----------------------------------------
   // outputs, all from flip-flops cleared by reset
   // ----------------------------------------
   assign antenna_frame_timer = tmr_all[`FSY_TW-1:0];
   assign system_timer = tmr_all[2*`FSY_TW-1:`FSY_TW];
   assign gps_time_counter = gps_reg;
   assign frame_clock_out = fclk_reg;
   assign error_event = err_reg;
   assign alarm_event = alarm_reg;
   assign wdog_expired = wd_exp_reg;
   assign timer_running = run_reg;
endmodule // fsy_frame_timing

// ===== rtl/fsy_sync_capture.v
`timescale 1ns/1ps
// ----------------------------------------
// sync pair capture: three-stage synchronisers, edge find on the pair clock
// ----------------------------------------
module fsy_sync_capture (
   input wire sys_clk,
   input wire arst_n,
   input wire sync_pin,
   input wire clock_pin,
   output wire boundary
);
   reg [2:0] clk_sr_reg;
   reg [2:0] sync_sr_reg;
   reg clk_lvl_reg;
   reg sync_lvl_reg;
   reg [1:0] sync_dly_reg;
   reg boundary_reg;
   wire clk_rise;

   // a change counts only once stages two and three agree
   assign clk_rise = clk_sr_reg[1] & clk_sr_reg[2] & ~clk_lvl_reg;

   always @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         clk_sr_reg <= 3'h0;
         sync_sr_reg <= 3'h0;
         clk_lvl_reg <= 1'b0;
         sync_lvl_reg <= 1'b0;
         sync_dly_reg <= 2'h0;
         boundary_reg <= 1'b0;
      end else begin
         clk_sr_reg <= {clk_sr_reg[1:0], clock_pin};
         sync_sr_reg <= {sync_sr_reg[1:0], sync_pin};
         if (clk_sr_reg[1] == clk_sr_reg[2]) begin
            clk_lvl_reg <= clk_sr_reg[2];
         end
         if (sync_sr_reg[1] == sync_sr_reg[2]) begin
            sync_lvl_reg <= sync_sr_reg[2];
         end
         // use the sync level from before the edge: the source changes sync on that same edge
         sync_dly_reg <= {sync_dly_reg[0], sync_lvl_reg};
         boundary_reg <= clk_rise & sync_dly_reg[1];
      end
   end

   assign boundary = boundary_reg;
endmodule // fsy_sync_capture

// ===== verification/fsy_frame_timing_bench.sv
`timescale 1ns/1ps
`include "fsy_consts.vh"
module fsy_frame_timing_bench;
   logic sys_clk = 1'b0;
   logic arst_n = 1'b1;
   logic [2:0] mark_req = 3'h0;
   wire [2:0] pin_sync;
   wire [2:0] pin_clk;
   logic sync_mode = 1'b0;
   logic sys_src_sel = 1'b0;
   logic [1:0] timer_arm = 2'h0;
   logic [1:0] timer_halt = 2'h0;
   logic [`FSY_WDOG_W-1:0] wdog_limit = 24'h0000c8;
   logic [`FSY_GPS_W-1:0] gps_time_init = 32'h12345678;
   logic [`FSY_NUM_EVT-1:0] evt_enable = 30'h00000007;
   logic [`FSY_NUM_EVT-1:0] evt_timer_sel = 30'h00000002;
   logic [`FSY_NUM_EVT*`FSY_TW-1:0] evt_period = '0;
   logic [`FSY_NUM_EVT*`FSY_TW-1:0] evt_offset = '0;
   wire [`FSY_NUM_EVT-1:0] system_event;
   wire frame_clock_out, error_event, alarm_event, wdog_expired;
   wire [`FSY_TW-1:0] antenna_frame_timer, system_timer;
   wire [`FSY_GPS_W-1:0] gps_time_counter;
   wire [1:0] timer_running;
   wire [31:0] pulses = {alarm_event, error_event, system_event};
   int n_fail = 0;
   int n_checks = 0;
   int cyc = 0;
   int n_alarm = 0;
   int n;
   int a0;
   logic [15:0] held;

   always #5 sys_clk = ~sys_clk;

   // ----
   // sync sources: burst, alternate frame, system tick
   // ----
   genvar g;
   for (g = 0; g < 3; g++) begin : src
      fsy_sync_source fsy_sync_source_inst (.req(mark_req[g]), .sync_out(pin_sync[g]), .clk_out(pin_clk[g]));
   end
   fsy_frame_timing fsy_frame_timing_inst (
      .sys_clk(sys_clk), .arst_n(arst_n), .rp1_sync_burst(pin_sync[0]), .rp1_sync_clock(pin_clk[0]),
      .alt_frame_sync(pin_sync[1]), .alt_frame_clock(pin_clk[1]), .system_tick_sync(pin_sync[2]),
      .system_tick_clock(pin_clk[2]), .sync_mode(sync_mode), .sys_src_sel(sys_src_sel),
      .timer_arm(timer_arm), .timer_halt(timer_halt), .wdog_limit(wdog_limit), .gps_time_init(gps_time_init),
      .evt_enable(evt_enable), .evt_timer_sel(evt_timer_sel), .evt_period(evt_period),
      .evt_offset(evt_offset), .system_event(system_event), .frame_clock_out(frame_clock_out),
      .error_event(error_event), .alarm_event(alarm_event), .antenna_frame_timer(antenna_frame_timer),
      .system_timer(system_timer), .gps_time_counter(gps_time_counter), .wdog_expired(wdog_expired),
      .timer_running(timer_running));

   // ----
   // checking tasks
   // ----
   task automatic chk_bit(input string what, input logic exp, input logic got);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %b seen %b", what, exp, got);
      end
   endtask
   task automatic chk_word(input string what, input logic [31:0] exp, input logic [31:0] got);
      n_checks++;
      if (got !== exp) begin
         n_fail++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask
   task automatic chk_reset_outputs();
      chk_word("outputs in reset", 32'h0, pulses | gps_time_counter | {antenna_frame_timer, system_timer}
         | {27'h0, frame_clock_out, wdog_expired, timer_running, 1'b0});
   endtask
   // a mark is given time for the pair clock edge to cross into sys_clk before anyone looks
   task automatic send_mark(input int which);
      @(negedge sys_clk) mark_req[which] = 1'b1;
      @(negedge sys_clk) mark_req[which] = 1'b0;
      repeat (30) @(negedge sys_clk);
   endtask
   task automatic wait_pulse(input int sel, input int lim, output int cnt);
      cnt = 0;
      while (pulses[sel] !== 1'b1 && cnt < lim) begin
         @(negedge sys_clk);
         cnt++;
      end
      @(negedge sys_clk);
   endtask
   task automatic tally_and_finish();
      $display("checks %0d failures %0d", n_checks, n_fail);
      if (n_fail == 0 && n_checks > 0) begin
         $display("ALL CHECKS OK");
      end else begin
         $display("CHECKS NOT OK");
      end
      $finish;
   endtask

   always @(negedge sys_clk) begin
      if (alarm_event === 1'b1) n_alarm++;
   end
   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 20000) begin
         n_fail++;
         tally_and_finish();
      end
   end

   // ----
   // test sequence
   // ----
   initial begin
      evt_period[15:0] = 16'h0003;
      evt_period[31:16] = 16'h0001;
      evt_period[47:32] = 16'h0003;
      evt_offset[47:32] = 16'h0002;
      // reset falls just after time zero so every flip-flop sees its clearing edge
      #1 arst_n = 1'b0;
      repeat (8) @(negedge sys_clk);
      chk_reset_outputs();
      arst_n = 1'b1;
      send_mark(1);
      chk_bit("idle ignores mark", 1'b0, timer_running[0]);
      timer_arm = 2'b01;
      send_mark(1);
      chk_bit("antenna running", 1'b1, timer_running[0]);
      chk_bit("frame clock out", 1'b1, frame_clock_out);
      chk_word("gps time", gps_time_init, gps_time_counter);
      wait_pulse(0, 400, n);
      wait_pulse(0, 400, n);
      chk_word("event 0 spacing", 32'h00000068, n + 1);
      wait_pulse(2, 400, n);
      chk_word("event 2 offset", 32'h00000034, n + 1);
      timer_halt = 2'b01;
      repeat (3) @(negedge sys_clk);
      held = antenna_frame_timer;
      repeat (60) @(negedge sys_clk);
      chk_word("halted timer", {16'h0, held}, {16'h0, antenna_frame_timer});
      timer_halt = 2'b00;
      repeat (60) @(negedge sys_clk);
      chk_bit("timer resumes", 1'b1, antenna_frame_timer != held);
      sys_src_sel = 1'b1;
      timer_arm = 2'b11;
      send_mark(2);
      chk_bit("system running", 1'b1, timer_running[1]);
      wait_pulse(1, 400, n);
      wait_pulse(1, 400, n);
      chk_word("event 1 spacing", 32'h00000034, n + 1);
      sync_mode = 1'b1;
      wait_pulse(30, 400, n);
      chk_bit("watchdog error", 1'b1, n < 400);
      chk_bit("watchdog flag", 1'b1, wdog_expired);
      a0 = n_alarm;
      send_mark(0);
      chk_word("one alarm per mark", a0 + 1, n_alarm);
      chk_bit("watchdog cleared", 1'b0, wdog_expired);
      chk_bit("system timer realigned", 1'b1, system_timer < 16'h0002);
      chk_word("gps time after mark", gps_time_init + 32'h00000001, gps_time_counter);
      arst_n = 1'b0;
      repeat (2) @(negedge sys_clk);
      chk_reset_outputs();
      arst_n = 1'b1;
      tally_and_finish();
   end
endmodule // fsy_frame_timing_bench

// ===== verification/fsy_frame_timing_properties.sv
`timescale 1ns/1ps
`include "fsy_consts.vh"
module fsy_frame_timing_properties (
   input wire sys_clk,
   input wire arst_n,
   input wire sync_mode,
   input wire [1:0] timer_arm,
   input wire [1:0] timer_halt,
   input wire [`FSY_NUM_EVT-1:0] system_event,
   input wire frame_clock_out,
   input wire error_event,
   input wire alarm_event,
   input wire [`FSY_TW-1:0] antenna_frame_timer,
   input wire wdog_expired,
   input wire [1:0] timer_running
);
   default clocking @(posedge sys_clk); endclocking
   default disable iff (!arst_n);
   evt_pulse_a: assert property ((system_event & $past(system_event)) == '0)
      else $error("event strobe held");
   err_pulse_a: assert property (error_event |=> !error_event)
      else $error("error strobe held");
   alarm_pulse_a: assert property (alarm_event |=> !alarm_event)
      else $error("alarm strobe held");
   err_flag_a: assert property (error_event |-> ##[0:1] wdog_expired)
      else $error("expiry flag not set");
   // the mode is registered, so the watchdog may still fire a few cycles after leaving it
   err_mode_a: assert property (!sync_mode && !$past(sync_mode) && !$past(sync_mode, 2)
      && !$past(sync_mode, 3) && !$past(sync_mode, 4) |-> !error_event) else $error("watchdog outside mode");
   fclk_range_a: assert property (frame_clock_out |-> antenna_frame_timer <= 16'h0780)
      else $error("frame clock high late");
   halt_freeze_a: assert property (timer_halt[0] && $past(timer_halt[0]) && $past(timer_halt[0], 2)
      |-> $stable(antenna_frame_timer)) else $error("halted timer moved");
   idle_run_a: assert property (!timer_arm[0] && !$past(timer_arm[0]) && !$past(timer_arm[0], 2)
      |-> !timer_running[0]) else $error("running without arm");
   count_step_a: assert property ($changed(antenna_frame_timer) |->
      antenna_frame_timer == $past(antenna_frame_timer) + 16'h0001 || antenna_frame_timer == 16'h0000)
      else $error("timer step wrong");
   reset_low_a: assert property (disable iff (1'b0) !arst_n |-> system_event == '0 && !frame_clock_out
      && !error_event && !alarm_event && antenna_frame_timer == '0 && !wdog_expired && timer_running == 2'h0)
      else $error("output high in reset");
endmodule // fsy_frame_timing_properties

bind fsy_frame_timing fsy_frame_timing_properties fsy_frame_timing_properties_inst (
   .sys_clk(sys_clk), .arst_n(arst_n), .sync_mode(sync_mode), .timer_arm(timer_arm),
   .timer_halt(timer_halt), .system_event(system_event), .frame_clock_out(frame_clock_out),
   .error_event(error_event), .alarm_event(alarm_event), .antenna_frame_timer(antenna_frame_timer),
   .wdog_expired(wdog_expired), .timer_running(timer_running));

// ===== verification/fsy_sync_source.sv
`timescale 1ns/1ps
// ----
// external timing source: one framed sync pulse per request
// ----
module fsy_sync_source (
   input wire req,
   output logic sync_out,
   output logic clk_out
);
   initial begin
      sync_out = 1'b0;
      clk_out = 1'b0;
   end
   // pair clock stands still between marks, so only one rising edge per mark
   always @(posedge req) begin
      sync_out = 1'b1;
      #40 clk_out = 1'b1;
      #40 clk_out = 1'b0;
      sync_out = 1'b0;
   end
endmodule // fsy_sync_source
